// ---- inc/msps_regs.vh ----
`ifndef MSPS_REGS_VH
`define MSPS_REGS_VH

// reported module state codes
`define MSPS_ST_RESETTING 3'h0
`define MSPS_ST_RESET 3'h1
`define MSPS_ST_INIT 3'h2
`define MSPS_ST_LOWPWR 3'h3
`define MSPS_ST_PWRUP 3'h4
`define MSPS_ST_READY 3'h5
`define MSPS_ST_PWRDN 3'h6
`define MSPS_ST_FAULT 3'h7

// peak power advert byte, page 00h
`define MSPS_PEAK_POWER_OFFSET 8'hC9
`define MSPS_PEAK_POWER_DEFAULT 8'h00

// interface init wait, in microseconds
`define MSPS_INIT_WAIT_US 2000
`define MSPS_CLK_MHZ 100
`define MSPS_INIT_WAIT_CYCLES (`MSPS_INIT_WAIT_US * `MSPS_CLK_MHZ)

// shutdown and power step durations, cycles
`define MSPS_SHUTDOWN_CYCLES 16
`define MSPS_PWRUP_CYCLES 16
`define MSPS_PWRDN_CYCLES 16

`endif

// ---- rtl/msps_timer.v ----
`timescale 1ns/1ps
`default_nettype none
module msps_timer #(
    parameter WIDTH = 24
)(
    input wire clk,
    input wire rst,
    input wire start,
    input wire [WIDTH-1:0] load,
    output wire done
);
    reg [WIDTH-1:0] cnt_reg;
    reg run_reg;
    reg done_reg;

    assign done = done_reg;

    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt_reg <= {WIDTH{1'b0}};
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg <= load;
            run_reg <= 1'b1;
            done_reg <= 1'b0;
        end
        else if (run_reg)
        begin
            if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1})
            begin
                run_reg <= 1'b0;
                done_reg <= 1'b1;
            end
            cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
        else
        begin
            done_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/msps_sequencer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "msps_regs.vh"
module msps_sequencer #(
    parameter FLAT_MEMORY = 0,
    parameter INIT_WAIT_CYCLES = `MSPS_INIT_WAIT_CYCLES,
    parameter [7:0] PEAK_POWER = `MSPS_PEAK_POWER_DEFAULT
)(
    input wire CLK,
    input wire RESET,
    input wire RESET_PIN,
    input wire SOFT_RESET_WRITE,
    input wire SUPPLY_RESET_INPUT_N,
    input wire POWER_GOOD,
    input wire LOW_POWER_REQUEST,
    input wire ALL_PATHS_IDLE,
    input wire FAULT_DETECT,
    input wire STATE_CHANGE_FLAG_CLEAR,
    output reg [2:0] MODULE_STATE,
    output reg [2:0] REPORTED_STATE,
    output reg HIGH_POWER,
    output reg ELECTRONICS_RESET,
    output reg CONFIG_MEM_RESET,
    output reg MGMT_READY,
    output reg MGMT_IGNORE,
    output reg INTERRUPT_ENABLE,
    output reg DEFAULTS_LOAD,
    output reg PATHS_DISCARD,
    output reg PATH_ENABLE,
    output reg SOFT_RESET_BIT,
    output reg STATE_CHANGE_FLAG,
    output reg [7:0] PEAK_POWER_ADVERT
);
    localparam [2:0] S_RESETTING = `MSPS_ST_RESETTING;
    localparam [2:0] S_RESET = `MSPS_ST_RESET;
    localparam [2:0] S_INIT = `MSPS_ST_INIT;
    localparam [2:0] S_LOWPWR = `MSPS_ST_LOWPWR;
    localparam [2:0] S_PWRUP = `MSPS_ST_PWRUP;
    localparam [2:0] S_READY = `MSPS_ST_READY;
    localparam [2:0] S_PWRDN = `MSPS_ST_PWRDN;
    localparam [2:0] S_FAULT = `MSPS_ST_FAULT;
    localparam TW = 28;
    // counts are 32-bit integers; cut to the timer width on purpose
    localparam [31:0] INIT_WIDE = INIT_WAIT_CYCLES;
    localparam [31:0] SHUT_WIDE = `MSPS_SHUTDOWN_CYCLES;
    localparam [31:0] UP_WIDE = `MSPS_PWRUP_CYCLES;
    localparam [31:0] DN_WIDE = `MSPS_PWRDN_CYCLES;
    localparam [TW-1:0] INIT_LOAD = INIT_WIDE[TW-1:0];
    localparam [TW-1:0] SHUT_LOAD = SHUT_WIDE[TW-1:0];
    localparam [TW-1:0] UP_LOAD = UP_WIDE[TW-1:0];
    localparam [TW-1:0] DN_LOAD = DN_WIDE[TW-1:0];

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg timer_start;
    reg [TW-1:0] timer_load;
    wire timer_done;
    wire reset_condition;
    wire low_power_exit_condition;
    wire entering;
    wire soft_clear;
    wire flag_set;

    // reset and shutdown both keep the electronics down
    function in_ground;
        input [2:0] st;
        begin
            in_ground = (st == S_RESET) || (st == S_RESETTING);
        end
    endfunction

    // management link unusable until init has finished
    function mgmt_off;
        input [2:0] st;
        begin
            mgmt_off = in_ground(st) || (st == S_INIT);
        end
    endfunction

    // power steps may already draw high power
    function high_power_mode;
        input [2:0] st;
        begin
            high_power_mode = (st == S_READY) || (st == S_PWRUP) ||
                (st == S_PWRDN);
        end
    endfunction

    // flat modules hide every internal state
    function [2:0] reported_code;
        input [2:0] st;
        begin
            reported_code = (FLAT_MEMORY != 0) ? S_READY : st;
        end
    endfunction

    // one-cycle strobe on the edge that enters a state
    function entry_to;
        input [2:0] st;
        input [2:0] nxt;
        input ent;
        begin
            entry_to = ent && (nxt == st);
        end
    endfunction

    // flat modules ignore soft and supply reset_condition
    assign reset_condition = RESET_PIN |
        ((FLAT_MEMORY == 0) & (SOFT_RESET_BIT | ~SUPPLY_RESET_INPUT_N));
    assign low_power_exit_condition = LOW_POWER_REQUEST & ALL_PATHS_IDLE;
    assign entering = (state_next != state_reg);
    assign soft_clear = entry_to(S_RESET, state_next, entering);
    // set wins over a clear in the same cycle
    assign flag_set = (FLAT_MEMORY == 0) && entering &&
        ((state_next == S_LOWPWR && !low_power_exit_condition) || state_next == S_READY);

    msps_timer #(
        .WIDTH(TW)
    ) u_timer (
        .clk(CLK),
        .rst(RESET),
        .start(timer_start),
        .load(timer_load),
        .done(timer_done)
    );

    always @*
    begin
        state_next = state_reg;
        // already shutting down: a held reset must not restart the shutdown timer
        if (reset_condition && state_reg != S_RESET && state_reg != S_RESETTING)
        begin
            state_next = S_RESETTING;
        end
        else
        begin
            case (state_reg)
                S_RESETTING:
                begin
                    if (timer_done)
                    begin
                        state_next = S_RESET;
                    end
                end
                S_RESET:
                begin
                    if (!reset_condition && POWER_GOOD)
                    begin
                        state_next = S_INIT;
                    end
                end
                S_INIT:
                begin
                    if (timer_done)
                    begin
                        // flat modules go straight on to ready
                        state_next = (FLAT_MEMORY != 0) ? S_READY : S_LOWPWR;
                    end
                    else if (FAULT_DETECT && FLAT_MEMORY == 0)
                    begin
                        state_next = S_FAULT;
                    end
                end
                S_LOWPWR:
                begin
                    if (FAULT_DETECT)
                    begin
                        state_next = S_FAULT;
                    end
                    else if (!LOW_POWER_REQUEST)
                    begin
                        state_next = S_PWRUP;
                    end
                end
                S_PWRUP:
                begin
                    if (FAULT_DETECT)
                    begin
                        state_next = S_FAULT;
                    end
                    else if (LOW_POWER_REQUEST)
                    begin
                        state_next = S_PWRDN;
                    end
                    else if (timer_done)
                    begin
                        state_next = S_READY;
                    end
                end
                S_READY:
                begin
                    if (FLAT_MEMORY == 0 && FAULT_DETECT)
                    begin
                        state_next = S_FAULT;
                    end
                    else if (FLAT_MEMORY == 0 && low_power_exit_condition)
                    begin
                        state_next = S_PWRDN;
                    end
                end
                S_PWRDN:
                begin
                    // request ignored until back in idle
                    if (FAULT_DETECT)
                    begin
                        state_next = S_FAULT;
                    end
                    else if (timer_done)
                    begin
                        state_next = S_LOWPWR;
                    end
                end
                S_FAULT:
                begin
                    state_next = S_FAULT;
                end
                default:
                begin
                    state_next = S_RESET;
                end
            endcase
        end
    end

    always @*
    begin
        timer_start = 1'b0;
        timer_load = SHUT_LOAD;
        if (entering)
        begin
            case (state_next)
                S_RESETTING:
                begin
                    timer_start = 1'b1;
                    timer_load = SHUT_LOAD;
                end
                S_INIT:
                begin
                    timer_start = 1'b1;
                    timer_load = INIT_LOAD;
                end
                S_PWRUP:
                begin
                    timer_start = 1'b1;
                    timer_load = UP_LOAD;
                end
                S_PWRDN:
                begin
                    timer_start = 1'b1;
                    timer_load = DN_LOAD;
                end
                default:
                begin
                    timer_start = 1'b0;
                    timer_load = SHUT_LOAD;
                end
            endcase
        end
    end

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            state_reg <= S_RESET;
            MODULE_STATE <= S_RESET;
            REPORTED_STATE <= reported_code(S_RESET);
            HIGH_POWER <= 1'b0;
            ELECTRONICS_RESET <= 1'b1;
            CONFIG_MEM_RESET <= 1'b1;
            MGMT_READY <= 1'b0;
            MGMT_IGNORE <= 1'b1;
            INTERRUPT_ENABLE <= 1'b0;
            DEFAULTS_LOAD <= 1'b0;
            PATHS_DISCARD <= 1'b0;
            PATH_ENABLE <= 1'b0;
            SOFT_RESET_BIT <= 1'b0;
            STATE_CHANGE_FLAG <= 1'b0;
            PEAK_POWER_ADVERT <= `MSPS_PEAK_POWER_DEFAULT;
        end
        else
        begin
            state_reg <= state_next;
            MODULE_STATE <= state_next;
            // flat modules never expose internal states
            REPORTED_STATE <= reported_code(state_next);
            // high power only in ready and power steps
            HIGH_POWER <= high_power_mode(state_next);
            ELECTRONICS_RESET <= in_ground(state_next);
            CONFIG_MEM_RESET <= in_ground(state_next) || ((FLAT_MEMORY != 0) && RESET_PIN);
            MGMT_READY <= !mgmt_off(state_next);
            // management accesses ignored while down or initialising
            MGMT_IGNORE <= mgmt_off(state_next);
            INTERRUPT_ENABLE <= (state_next != S_RESET) && (FLAT_MEMORY == 0);
            DEFAULTS_LOAD <= entry_to(S_INIT, state_next, entering);
            PATHS_DISCARD <= entry_to(S_RESETTING, state_next, entering) && (FLAT_MEMORY == 0);
            // flat path stays active through reset; paged needs ready
            PATH_ENABLE <= (FLAT_MEMORY != 0) ? 1'b1 : (state_next == S_READY);
            if (soft_clear)
            begin
                SOFT_RESET_BIT <= 1'b0;
            end
            else if (SOFT_RESET_WRITE && state_reg != S_RESET)
            begin
                SOFT_RESET_BIT <= 1'b1;
            end
            if (flag_set)
            begin
                STATE_CHANGE_FLAG <= 1'b1;
            end
            else if (STATE_CHANGE_FLAG_CLEAR || state_next == S_INIT)
            begin
                STATE_CHANGE_FLAG <= 1'b0;
            end
            PEAK_POWER_ADVERT <= PEAK_POWER;
        end
    end
endmodule
`default_nettype wire

// ---- test/msps_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msps_regs.vh"
module msps_checker #(
    parameter FLAT_MEMORY = 0
)(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic RESET_PIN,
    input wire logic SOFT_RESET_WRITE,
    input wire logic SUPPLY_RESET_INPUT_N,
    input wire logic POWER_GOOD,
    input wire logic LOW_POWER_REQUEST,
    input wire logic ALL_PATHS_IDLE,
    input wire logic FAULT_DETECT,
    input wire logic [2:0] MODULE_STATE,
    input wire logic [2:0] REPORTED_STATE,
    input wire logic HIGH_POWER,
    input wire logic ELECTRONICS_RESET,
    input wire logic INTERRUPT_ENABLE,
    input wire logic PATHS_DISCARD,
    input wire logic SOFT_RESET_BIT
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RESET);
    wire [2:0] s = MODULE_STATE;
    wire q = !RESET_PIN && !SOFT_RESET_WRITE && !SOFT_RESET_BIT && SUPPLY_RESET_INPUT_N && !FAULT_DETECT;
    wire ex = LOW_POWER_REQUEST && ALL_PATHS_IDLE;
    wire in_rs = s == `MSPS_ST_RESETTING;
    logic [4:0] pu_cnt;
    // counter: power-up is longer than a repetition may span
    always @(posedge CLK)
        pu_cnt <= (s == `MSPS_ST_PWRUP) ? pu_cnt + 5'h01 : 5'h00;
    chk_high_power: assert property (FLAT_MEMORY == 0 |->
        HIGH_POWER == (s inside {`MSPS_ST_PWRUP, `MSPS_ST_READY, `MSPS_ST_PWRDN})) else $error("power mode");
    chk_flat_report: assert property (FLAT_MEMORY == 0 || REPORTED_STATE == `MSPS_ST_READY)
        else $error("flat report");
    chk_reset_entry: assert property (RESET_PIN && !in_rs && s != `MSPS_ST_RESET |=> in_rs)
        else $error("no shutdown");
    chk_ground_exit: assert property (s == `MSPS_ST_RESET && q && POWER_GOOD |=> s == `MSPS_ST_INIT)
        else $error("ground exit");
    chk_init_exit: assert property ($past(s) == `MSPS_ST_INIT && !(s inside {`MSPS_ST_INIT, `MSPS_ST_RESETTING,
        `MSPS_ST_FAULT}) |-> s == (FLAT_MEMORY ? `MSPS_ST_READY : `MSPS_ST_LOWPWR)) else $error("init exit");
    chk_idle_up: assert property (s == `MSPS_ST_LOWPWR && q && !LOW_POWER_REQUEST |=> s == `MSPS_ST_PWRUP)
        else $error("no power up");
    chk_pwrup_down: assert property (s == `MSPS_ST_PWRUP && q && LOW_POWER_REQUEST |=> s == `MSPS_ST_PWRDN)
        else $error("no power down");
    chk_ready_exit: assert property (FLAT_MEMORY == 0 && s == `MSPS_ST_READY && q |=>
        s == ($past(ex) ? `MSPS_ST_PWRDN : `MSPS_ST_READY)) else $error("ready exit");
    chk_pwrup_bound: assert property (pu_cnt < 5'h18)
        else $error("power up too long");
    chk_shutdown_done: assert property ($past(in_rs) && !in_rs |-> s == `MSPS_ST_RESET)
        else $error("shutdown exit");
    chk_discard_pulse: assert property (FLAT_MEMORY == 0 && $rose(in_rs) |-> PATHS_DISCARD ##1 !PATHS_DISCARD)
        else $error("discard pulse");
    chk_ground_quiet: assert property (s == `MSPS_ST_RESET |->
        ELECTRONICS_RESET && !HIGH_POWER && !INTERRUPT_ENABLE && !SOFT_RESET_BIT) else $error("ground outputs");
    cover property (FLAT_MEMORY == 0 && s == `MSPS_ST_READY);
    cover property ($rose(in_rs));
    cover property (s == `MSPS_ST_FAULT);
endmodule
bind msps_sequencer msps_checker #(.FLAT_MEMORY(FLAT_MEMORY)) msps_checker_i (.*);
`default_nettype wire

// ---- test/msps_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module msps_host_model #(
    parameter [7:0] WAIT = 8'h14
)(
    input wire logic clk,
    input wire logic erst,
    input wire logic flag,
    input wire logic want_low,
    input wire logic [3:0] clr_dly,
    output logic lpr,
    output logic fclr
);
    logic [7:0] up_cnt = 8'h00;
    logic [3:0] fl_cnt = 4'h0;
    initial lpr = 1'b1;
    initial fclr = 1'b0;
    always @(posedge clk)
    begin
        up_cnt <= erst ? 8'h00 : up_cnt + {7'h00, up_cnt != 8'hFF};
        // stays in low power until the init wait has run out
        lpr <= want_low || up_cnt <= WAIT;
        fl_cnt <= flag ? fl_cnt + 4'h1 : 4'h0;
        // prompt or slow clear of the sticky flag
        fclr <= flag && fl_cnt == clr_dly;
    end
endmodule
`default_nettype wire

// ---- test/msps_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msps_regs.vh"
module msps_sequencer_tb;
    logic CLK, RESET, RESET_PIN, SOFT_RESET_WRITE, SUPPLY_RESET_INPUT_N, POWER_GOOD, ALL_PATHS_IDLE, FAULT_DETECT;
    logic want_low;
    logic [3:0] clr_dly;
    wire LOW_POWER_REQUEST, STATE_CHANGE_FLAG_CLEAR, HIGH_POWER, ELECTRONICS_RESET, CONFIG_MEM_RESET, MGMT_READY;
    wire MGMT_IGNORE, INTERRUPT_ENABLE, DEFAULTS_LOAD, PATHS_DISCARD, PATH_ENABLE, SOFT_RESET_BIT, STATE_CHANGE_FLAG;
    wire [2:0] MODULE_STATE, REPORTED_STATE, flat_rep;
    wire [7:0] PEAK_POWER_ADVERT;
    integer failures, cmp_count, seed, i;
    msps_sequencer #(.INIT_WAIT_CYCLES(20), .PEAK_POWER(8'h5A)) msps_sequencer_i (.*);
    msps_sequencer #(.FLAT_MEMORY(1), .INIT_WAIT_CYCLES(20)) msps_sequencer_flat_i (.REPORTED_STATE(flat_rep),
        .MODULE_STATE(), .HIGH_POWER(), .ELECTRONICS_RESET(), .CONFIG_MEM_RESET(), .MGMT_READY(), .MGMT_IGNORE(),
        .INTERRUPT_ENABLE(), .DEFAULTS_LOAD(), .PATHS_DISCARD(), .PATH_ENABLE(), .SOFT_RESET_BIT(),
        .STATE_CHANGE_FLAG(), .PEAK_POWER_ADVERT(), .*);
    msps_host_model msps_host_model_i (.clk(CLK), .erst(ELECTRONICS_RESET), .flag(STATE_CHANGE_FLAG),
        .want_low(want_low), .clr_dly(clr_dly), .lpr(LOW_POWER_REQUEST), .fclr(STATE_CHANGE_FLAG_CLEAR));
    task complete_run;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wst(input logic [2:0] s);
        integer n;
        n = 0;
        while (MODULE_STATE !== s && n < 300)
        begin
            @(negedge CLK);
            n = n + 1;
        end
        if (MODULE_STATE !== s)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %0t: state wait", $time);
            complete_run;
        end
    endtask
    function logic exp_flag(input logic lp, input logic id);
        return !(lp && id);
    endfunction
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial
    begin
        seed = 15;
        failures = 0;
        cmp_count = 0;
        want_low = 1'b1;
        clr_dly = 4'h3;
        RESET = 1'b1;
        RESET_PIN = 1'b0;
        SOFT_RESET_WRITE = 1'b0;
        SUPPLY_RESET_INPUT_N = 1'b1;
        POWER_GOOD = 1'b1;
        ALL_PATHS_IDLE = 1'b0;
        FAULT_DETECT = 1'b0;
        repeat (4) @(negedge CLK);
        cmp(MODULE_STATE, `MSPS_ST_RESET);
        RESET = 1'b0;
        wst(`MSPS_ST_INIT);
        cmp(HIGH_POWER, 1'b0);
        cmp(DEFAULTS_LOAD, 1'b1);
        cmp(MGMT_IGNORE, 1'b1);
        cmp(MGMT_READY, 1'b0);
        wst(`MSPS_ST_LOWPWR);
        cmp(STATE_CHANGE_FLAG, exp_flag(LOW_POWER_REQUEST, ALL_PATHS_IDLE));
        cmp(PEAK_POWER_ADVERT, 8'h5A);
        cmp(flat_rep, `MSPS_ST_READY);
        cmp(REPORTED_STATE, `MSPS_ST_LOWPWR);
        cmp(MGMT_READY, 1'b1);
        cmp(MGMT_IGNORE, 1'b0);
        $display("boot test done");
        want_low = 1'b0;
        wst(`MSPS_ST_READY);
        cmp(HIGH_POWER, 1'b1);
        want_low = 1'b1;
        repeat (6) @(negedge CLK);
        cmp(PATH_ENABLE, 1'b1);
        cmp(MODULE_STATE, `MSPS_ST_READY);
        ALL_PATHS_IDLE = 1'b1;
        wst(`MSPS_ST_PWRDN);
        wst(`MSPS_ST_LOWPWR);
        cmp(STATE_CHANGE_FLAG, exp_flag(1'b1, ALL_PATHS_IDLE));
        $display("power mode test done");
        for (i = 0; i < 40; i = i + 1)
        begin
            @(negedge CLK);
            want_low = $random(seed);
            ALL_PATHS_IDLE = $random(seed);
            clr_dly = $random(seed);
            repeat ($random(seed) & 31) @(negedge CLK);
        end
        want_low = 1'b1;
        ALL_PATHS_IDLE = 1'b1;
        wst(`MSPS_ST_LOWPWR);
        $display("random test done");
        // pin, soft bit and supply input in turn; power loss keeps the ground state
        for (i = 0; i < 3; i = i + 1)
        begin
            RESET_PIN = i == 0;
            SOFT_RESET_WRITE = i == 1;
            SUPPLY_RESET_INPUT_N = i != 2;
            wst(`MSPS_ST_RESETTING);
            cmp(PATHS_DISCARD, 1'b1);
            cmp(MGMT_IGNORE, 1'b1);
            POWER_GOOD = 1'b0;
            wst(`MSPS_ST_RESET);
            cmp(SOFT_RESET_BIT, 1'b0);
            cmp(CONFIG_MEM_RESET, 1'b1);
            cmp(INTERRUPT_ENABLE, 1'b0);
            cmp(HIGH_POWER, 1'b0);
            cmp(flat_rep, `MSPS_ST_READY);
            RESET_PIN = 1'b0;
            SOFT_RESET_WRITE = 1'b0;
            SUPPLY_RESET_INPUT_N = 1'b1;
            repeat (4) @(negedge CLK);
            cmp(MODULE_STATE, `MSPS_ST_RESET);
            POWER_GOOD = 1'b1;
            wst(`MSPS_ST_LOWPWR);
        end
        $display("reset test done");
        FAULT_DETECT = 1'b1;
        @(negedge CLK);
        FAULT_DETECT = 1'b0;
        want_low = 1'b0;
        repeat (30) @(negedge CLK);
        cmp(MODULE_STATE, `MSPS_ST_FAULT);
        RESET_PIN = 1'b1;
        wst(`MSPS_ST_RESETTING);
        RESET_PIN = 1'b0;
        wst(`MSPS_ST_READY);
        $display("fault test done");
        complete_run;
    end
endmodule
`default_nettype wire
